// File: uag_pkg.sv
/*
 * constants for the serial transmitter/receiver with baud generator.
 * assumes one core clock; register port offsets are local choices.
 */
package uag_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [2:0] UAG_A_MODE = 3'h0; // serial_mode_reg
    localparam logic [2:0] UAG_A_ERR  = 3'h1; // rx_error_status_reg
    localparam logic [2:0] UAG_A_BAUD = 3'h2; // baud_divider_control
    localparam logic [2:0] UAG_A_TXS  = 3'h3; // tx_shift_reg (write)
    localparam logic [2:0] UAG_A_RXB  = 3'h4; // rx_buffer_reg (read)
    // ------------------------------------------------------------
    // mode register fields
    // ------------------------------------------------------------
    localparam int UAG_M_PWR  = 7; // unit_power_on
    localparam int UAG_M_TXE  = 6; // tx_enable_bit
    localparam int UAG_M_RXE  = 5; // rx_enable_bit
    localparam int UAG_M_PSH  = 4; // parity_sel_hi
    localparam int UAG_M_PSL  = 3; // parity_sel_lo
    localparam int UAG_M_CL   = 2; // char_length_sel, 1 = 8 bits
    localparam int UAG_M_SL   = 1; // stop_length_sel, 1 = 2 stops
    localparam logic [7:0] UAG_MODE_RST = 8'h01; // bit 0 reads one
    localparam logic [7:0] UAG_BAUD_RST = 8'h48; // base = core/2, k = 8
    // ------------------------------------------------------------
    // error flags and parity codes
    // ------------------------------------------------------------
    localparam int UAG_E_PE  = 2; // parity_err_flag
    localparam int UAG_E_FE  = 1; // framing error
    localparam int UAG_E_OVE = 0; // overrun_err_flag
    localparam logic [1:0] UAG_P_NONE = 2'h0;
    localparam logic [1:0] UAG_P_ZERO = 2'h1;
    localparam logic [1:0] UAG_P_ODD  = 2'h2;
    localparam logic [1:0] UAG_P_EVEN = 2'h3;
    // ------------------------------------------------------------
    // base clock select codes and prescaler masks
    // ------------------------------------------------------------
    localparam logic [1:0] UAG_B_TMR = 2'h0; // ext_timer_output
    localparam logic [1:0] UAG_B_D2  = 2'h1;
    localparam logic [1:0] UAG_B_D8  = 2'h2;
    localparam logic [1:0] UAG_B_D32 = 2'h3;
    localparam logic [4:0] UAG_PS_M2  = 5'h01;
    localparam logic [4:0] UAG_PS_M8  = 5'h07;
    localparam logic [4:0] UAG_PS_M32 = 5'h1f;
    localparam int UAG_K_MIN = 8; // least valid divider
endpackage : uag_pkg

// File: uag_baud_cnt.sv
/*
 * one 5-bit baud counter, counts base clock ticks up to k.
 * assumes base_tick_i is a one-cycle enable in the core clock.
 */
`timescale 1ns/1ps
module uag_baud_cnt
    import uag_pkg::*;
#(
    parameter int W = 5 // counter width
) (
    input  wire logic         core_clk_i,
    input  wire logic         resetn_i,
    input  wire logic         run_i,       // low holds count at zero
    input  wire logic         base_tick_i, // base clock enable
    input  wire logic [W-1:0] k_i,         // divider value
    output logic              tick_o,      // k base ticks elapsed
    output logic [W-1:0]      cnt_o
);
    initial begin
        if (W < 4) $error("uag_baud_cnt: width too small for k");
    end

    logic [W-1:0] cnt_ff; // base tick count

    // tick when the k-th base tick arrives
    assign tick_o = run_i && base_tick_i && (cnt_ff == k_i - 1'b1);
    assign cnt_o  = cnt_ff;

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_ff <= '0;
        end else if (!run_i) begin
            cnt_ff <= '0; // RULE19 RULE20
        end else if (tick_o) begin
            cnt_ff <= '0;
        end else if (base_tick_i) begin
            cnt_ff <= cnt_ff + 1'b1;
        end
    end

    a_cnt_held: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        !run_i |=> cnt_ff == '0) else $error("counter not held at zero"); // RULE19
endmodule : uag_baud_cnt

// File: uag_serial.sv
/*
 * full-duplex asynchronous serial transmitter and receiver with
 * base clock prescaler and separate transmit and receive counters.
 * assumes a plain register port with read data one cycle later and
 * serial_in_pin_i / ext_timer_output_i synchronous to core_clk_i.
 */
// Our own choices: strobed register access and the placing of the registers.
// Notes on behaviour
// RULE1 - no-parity mode sends no parity bit
// RULE2 - no-parity receive never flags parity error
// RULE3 - power then enable; each write sends frame
// RULE4 - start bit, then data lsb first
// RULE5 - done pulse right after last stop bit
// RULE6 - idle after frame until next write
// RULE7 - software waits for done before rewriting
// RULE8 - receiver samples only when powered and enabled
// RULE9 - falling edge starts counter, recheck confirms start
// RULE10 - stop bit: pulse, copy buffer unless overrun
// RULE11 - parity error finishes frame before reporting
// RULE12 - receiver checks one stop bit only
// RULE13 - parity, framing, overrun flags raise receive pulse
// RULE14 - reading error status clears all flags
// RULE15 - software reads status then buffer after error
// RULE16 - filter changes after two agreeing base samples
// RULE17 - base clock gated off while unpowered
// RULE18 - separate transmit and receive counters
// RULE19 - transmit counter held zero, cleared on write
// RULE20 - receive counter held zero, runs per frame
// RULE21 - baud is base clock over two k
// RULE22 - select timer, or core over 2, 8, 32
// RULE23 - power off stops and clears the block
// RULE24 - enable clear resets its own half
// RULE25 - frame: start, 7/8 data, parity, 1/2 stops
// RULE26 - even/odd parity counts ones, zero unchecked
// RULE27 - transmit line idles high
`timescale 1ns/1ps
module uag_serial
    import uag_pkg::*;
#(
    parameter int KW = 5 // divider width
) (
    input  wire logic       core_clk_i,
    input  wire logic       resetn_i,
    input  wire logic [2:0] addr_i,
    input  wire logic [7:0] wr_data_i,
    input  wire logic       wr_en_i,
    input  wire logic       rd_en_i,
    output logic      [7:0] rd_data_o,
    input  wire logic       serial_in_pin_i,
    input  wire logic       ext_timer_output_i,
    output logic            serial_out_pin_o,
    output logic            tx_done_irq_o,
    output logic            rx_done_irq_o
);
    initial begin
        if (KW != 5) $error("uag_serial: divider must be 5 bits");
    end

    typedef enum logic [1:0] {UAG_RX_IDLE, UAG_RX_START, UAG_RX_DATA} uag_rx_st_t;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [7:0]  mode_ff;      // serial_mode_reg
    logic [7:0]  baud_ff;      // baud_divider_control
    logic [2:0]  err_ff;       // rx_error_status_reg
    logic [7:0]  rxb_ff;       // rx_buffer_reg
    logic        rx_full_ff;   // buffer holds unread data
    logic [4:0]  ps_ff;        // prescaler
    logic        tmr_ff;       // last timer output level
    logic        base_tick;    // gated base clock enable
    logic        pwr, txe_on, rxe_on;
    logic [1:0]  psel;         // parity mode
    logic [KW-1:0] k_val;
    // transmit side
    logic        tx_busy_ff;
    logic        tx_half_ff;   // second half of the bit period
    logic [10:0] tx_sh_ff;     // bits still to send
    logic [3:0]  tx_left_ff;   // bits after the current one
    logic        tx_out_ff;
    logic        tx_load, tx_tick, tx_end;
    logic [11:0] tx_frame;     // line pattern of the byte being written
    // receive side
    uag_rx_st_t  rx_st_ff;
    logic        smp_a_ff, smp_b_ff; // filter samples
    logic        filt_ff, filt_d_ff; // filtered level and its past
    logic        rx_half_ff;
    logic [3:0]  rx_idx_ff;    // bit index within the frame
    logic [7:0]  rx_sh_ff;     // rx_shift_reg
    logic        rx_par_ff;    // running xor of ones
    logic        rx_tick, rx_smp, rx_fin, pe_now;
    logic [3:0]  rx_nch, rx_last;
    logic        err_rd, rxb_rd;

    // ------------------------------------------------------------
    // frame helpers
    // ------------------------------------------------------------
    // build the line pattern, start at bit 0, stops padded with ones
    function automatic logic [11:0] uag_frame(input logic [7:0] d,
                                              input logic cl8,
                                              input logic [1:0] ps);
        logic [11:0] v;
        logic        p;
        v = '1;
        p = cl8 ? ^d : ^d[6:0];
        v[0] = 1'b0;         // RULE4
        v[7:1] = d[6:0];     // RULE4
        if (cl8) v[8] = d[7];
        case (ps)
            UAG_P_ZERO: v[cl8 ? 9 : 8] = 1'b0;  // RULE26
            UAG_P_ODD:  v[cl8 ? 9 : 8] = ~p;    // RULE26
            UAG_P_EVEN: v[cl8 ? 9 : 8] = p;     // RULE26
            default:    v = v;                  // RULE1
        endcase
        return v;
    endfunction : uag_frame

    // data bits for the selected character length
    function automatic logic [3:0] uag_nchar(input logic cl8);
        return cl8 ? 4'h8 : 4'h7;
    endfunction : uag_nchar

    assign pwr    = mode_ff[UAG_M_PWR];
    assign txe_on = pwr && mode_ff[UAG_M_TXE];
    assign rxe_on = pwr && mode_ff[UAG_M_RXE];
    assign psel   = mode_ff[UAG_M_PSH:UAG_M_PSL];
    assign k_val  = baud_ff[KW-1:0]; // RULE21
    assign err_rd = rd_en_i && (addr_i == UAG_A_ERR);
    assign rxb_rd = rd_en_i && (addr_i == UAG_A_RXB);

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    // bit 0 of the mode register is fixed at one
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mode_ff <= UAG_MODE_RST;
            baud_ff <= UAG_BAUD_RST;
        end else if (wr_en_i) begin
            if (addr_i == UAG_A_MODE) mode_ff <= {wr_data_i[7:1], 1'b1};
            if (addr_i == UAG_A_BAUD) baud_ff <= wr_data_i;
        end
    end

    // read data stands one cycle after the strobe, else zero
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rd_data_o <= '0;
        end else if (rd_en_i) begin
            case (addr_i)
                UAG_A_MODE: rd_data_o <= mode_ff;
                UAG_A_ERR:  rd_data_o <= {5'h00, err_ff};
                UAG_A_BAUD: rd_data_o <= baud_ff;
                UAG_A_RXB:  rd_data_o <= rxb_ff;
                default:    rd_data_o <= 8'h00; // unmapped and write-only
            endcase
        end else begin
            rd_data_o <= '0;
        end
    end

    // ------------------------------------------------------------
    // base clock prescaler
    // ------------------------------------------------------------
    // free counter stopped and cleared while unpowered
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ps_ff  <= '0;
            tmr_ff <= 1'b0;
        end else begin
            ps_ff  <= pwr ? ps_ff + 1'b1 : 5'h00; // RULE23
            tmr_ff <= ext_timer_output_i;
        end
    end

    // one tick per base clock period, none while unpowered
    always_comb begin
        case (baud_ff[7:6])                                      // RULE22
            UAG_B_TMR: base_tick = ext_timer_output_i && !tmr_ff;
            UAG_B_D2:  base_tick = (ps_ff & UAG_PS_M2) == UAG_PS_M2;
            UAG_B_D8:  base_tick = (ps_ff & UAG_PS_M8) == UAG_PS_M8;
            default:   base_tick = ps_ff == UAG_PS_M32;
        endcase
        base_tick = base_tick && pwr;                            // RULE17
    end

    // ------------------------------------------------------------
    // baud counters, one per direction
    // ------------------------------------------------------------
    // a tick marks half a bit, so a bit spans 2k base ticks
    uag_baud_cnt #(.W(KW)) u_tx_cnt (                           // RULE18
        .core_clk_i  (core_clk_i),
        .resetn_i    (resetn_i),
        .run_i       (txe_on && !tx_load),                      // RULE19
        .base_tick_i (base_tick),
        .k_i         (k_val),
        .tick_o      (tx_tick),
        .cnt_o       ()
    );

    uag_baud_cnt #(.W(KW)) u_rx_cnt (                           // RULE18
        .core_clk_i  (core_clk_i),
        .resetn_i    (resetn_i),
        .run_i       (rxe_on && rx_st_ff != UAG_RX_IDLE),       // RULE20
        .base_tick_i (base_tick),
        .k_i         (k_val),
        .tick_o      (rx_tick),
        .cnt_o       ()
    );

    // ------------------------------------------------------------
    // transmitter
    // ------------------------------------------------------------
    // a write while a frame runs is dropped; software must wait
    assign tx_load = wr_en_i && addr_i == UAG_A_TXS && txe_on && !tx_busy_ff; // RULE3 RULE7
    assign tx_end  = tx_busy_ff && tx_tick && tx_half_ff && tx_left_ff == 4'h0;
    assign tx_frame = uag_frame(wr_data_i, mode_ff[UAG_M_CL], psel); // RULE1 RULE4

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_busy_ff <= 1'b0;
            tx_half_ff <= 1'b0;
            tx_sh_ff   <= '1;
            tx_left_ff <= '0;
            tx_out_ff  <= 1'b1;
        end else if (!txe_on) begin
            tx_busy_ff <= 1'b0;  // RULE24 RULE23
            tx_half_ff <= 1'b0;
            tx_sh_ff   <= '1;
            tx_left_ff <= '0;
            tx_out_ff  <= 1'b1;  // RULE27
        end else if (tx_load) begin
            tx_busy_ff <= 1'b1;  // RULE3
            tx_half_ff <= 1'b0;
            tx_sh_ff   <= tx_frame[11:1];
            tx_out_ff  <= 1'b0;  // RULE4
            // start + data + parity + stops, less the one on the line
            tx_left_ff <= uag_nchar(mode_ff[UAG_M_CL])                     // RULE25
                          + {3'h0, psel != UAG_P_NONE}                     // RULE1
                          + {3'h0, mode_ff[UAG_M_SL]}
                          + 4'h1;                                          // RULE5
        end else if (tx_busy_ff && tx_tick) begin
            tx_half_ff <= !tx_half_ff;
            if (tx_half_ff) begin
                if (tx_left_ff == 4'h0) begin
                    tx_busy_ff <= 1'b0; // RULE6
                    tx_out_ff  <= 1'b1; // RULE27
                end else begin
                    tx_out_ff  <= tx_sh_ff[0];
                    tx_sh_ff   <= {1'b1, tx_sh_ff[10:1]};
                    tx_left_ff <= tx_left_ff - 1'b1;
                end
            end
        end
    end

    assign serial_out_pin_o = tx_out_ff;
    assign tx_done_irq_o    = tx_end; // RULE5

    a_tx_idle_high: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // RULE27
        !tx_busy_ff |-> serial_out_pin_o) else $error("line not high while idle");
    a_tx_start_low: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // RULE4
        tx_load |=> !serial_out_pin_o && tx_busy_ff) else $error("no start bit");
    a_tx_done_idle: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // RULE5
        tx_done_irq_o |=> !tx_busy_ff && serial_out_pin_o) else $error("done not at frame end");

    // ------------------------------------------------------------
    // receive noise filter
    // ------------------------------------------------------------
    // input held high while unpowered; level moves on two equal samples
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            smp_a_ff  <= 1'b1;
            smp_b_ff  <= 1'b1;
            filt_ff   <= 1'b1;
            filt_d_ff <= 1'b1;
        end else if (!pwr) begin
            smp_a_ff  <= 1'b1;   // RULE23
            smp_b_ff  <= 1'b1;
            filt_ff   <= 1'b1;
            filt_d_ff <= 1'b1;
        end else if (base_tick) begin
            smp_a_ff  <= serial_in_pin_i;                     // RULE16
            smp_b_ff  <= smp_a_ff;
            if (smp_a_ff == smp_b_ff) filt_ff <= smp_a_ff;    // RULE16
            filt_d_ff <= filt_ff;
        end
    end

    a_filt_agree: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // RULE16
        $past(pwr) && $changed(filt_ff) |-> $past(smp_a_ff) == $past(smp_b_ff))
        else $error("filter moved without match");

    // ------------------------------------------------------------
    // receiver
    // ------------------------------------------------------------
    assign rx_nch  = uag_nchar(mode_ff[UAG_M_CL]);
    // last index is the first stop bit; a second stop is ignored
    assign rx_last = rx_nch + {3'h0, psel != UAG_P_NONE}; // RULE12 RULE2
    assign rx_smp  = rx_st_ff == UAG_RX_DATA && rx_tick && rx_half_ff;
    assign rx_fin  = rx_smp && rx_idx_ff == rx_last;
    // parity checked only for odd and even, never zero or none
    assign pe_now  = (psel == UAG_P_EVEN && rx_par_ff)    // RULE26
                  || (psel == UAG_P_ODD && !rx_par_ff);   // RULE2

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rx_st_ff   <= UAG_RX_IDLE;
            rx_half_ff <= 1'b0;
            rx_idx_ff  <= '0;
            rx_sh_ff   <= '0;
            rx_par_ff  <= 1'b0;
        end else if (!rxe_on) begin
            rx_st_ff   <= UAG_RX_IDLE; // RULE8 RULE24
            rx_half_ff <= 1'b0;
            rx_idx_ff  <= '0;
            rx_par_ff  <= 1'b0;
        end else begin
            case (rx_st_ff)
                UAG_RX_IDLE: begin
                    if (filt_d_ff && !filt_ff) rx_st_ff <= UAG_RX_START; // RULE9
                    rx_half_ff <= 1'b0;
                    rx_idx_ff  <= '0;
                    rx_par_ff  <= 1'b0;
                end
                UAG_RX_START: begin
                    // recheck at mid start bit; high means a glitch
                    if (rx_tick) rx_st_ff <= filt_ff ? UAG_RX_IDLE : UAG_RX_DATA; // RULE9
                end
                UAG_RX_DATA: begin
                    if (rx_tick) rx_half_ff <= !rx_half_ff;
                    if (rx_smp) begin
                        rx_idx_ff <= rx_idx_ff + 1'b1;
                        if (rx_idx_ff < rx_nch) rx_sh_ff <= {filt_ff, rx_sh_ff[7:1]};
                        if (rx_idx_ff < rx_last) rx_par_ff <= rx_par_ff ^ filt_ff;
                        if (rx_fin) rx_st_ff <= UAG_RX_IDLE; // RULE11 RULE20
                    end
                end
                default: rx_st_ff <= UAG_RX_IDLE;
            endcase
        end
    end

    assign rx_done_irq_o = rx_fin; // RULE10 RULE13

    // buffer and unread marker; overrun keeps the old byte
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rxb_ff     <= '0;
            rx_full_ff <= 1'b0;
        end else if (!pwr) begin
            rxb_ff     <= '0;   // RULE23
            rx_full_ff <= 1'b0;
        end else if (rx_fin && !rx_full_ff) begin
            rxb_ff     <= mode_ff[UAG_M_CL] ? rx_sh_ff : {1'b0, rx_sh_ff[7:1]}; // RULE10
            rx_full_ff <= 1'b1;
        end else if (rxb_rd) begin
            rx_full_ff <= 1'b0;
        end
    end

    // error flags: a frame ending in the read cycle still sets
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            err_ff <= '0;
        end else if (!pwr) begin
            err_ff <= '0; // RULE23
        end else if (rx_fin) begin
            err_ff[UAG_E_PE]  <= pe_now || (!err_rd && err_ff[UAG_E_PE]);   // RULE13
            err_ff[UAG_E_FE]  <= !filt_ff || (!err_rd && err_ff[UAG_E_FE]); // RULE13 RULE12
            err_ff[UAG_E_OVE] <= rx_full_ff || (!err_rd && err_ff[UAG_E_OVE]); // RULE13
        end else if (err_rd) begin
            err_ff <= '0; // RULE14
        end
    end

    a_par_none_ok: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // RULE2
        rx_fin && psel == UAG_P_NONE && !err_ff[UAG_E_PE] |=> !err_ff[UAG_E_PE])
        else $error("parity flag in no-parity mode");
    a_err_read_clr: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // RULE14
        err_rd && !rx_fin |=> err_ff == 3'h0) else $error("error read did not clear");
    a_ovr_keep_buf: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // RULE10
        rx_fin && rx_full_ff && pwr |=> $stable(rxb_ff) && err_ff[UAG_E_OVE])
        else $error("overrun overwrote buffer");
    a_rx_gate_off: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // RULE8
        !rxe_on |=> rx_st_ff == UAG_RX_IDLE && !rx_done_irq_o) else $error("receiver ran while disabled");
    a_base_gated: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // RULE17
        !pwr |-> !base_tick) else $error("base clock ran unpowered");
endmodule : uag_serial

// File: uag_remote_node.sv
/* remote serial node: sends frames into the block and decodes its frames.
   assumes 32 core clocks per bit (base = core/2, k = 8), 8 data bits. */
`timescale 1ns/1ps
module uag_remote_node (
    input  wire logic       core_clk_i,
    input  wire logic       line_i,      // block transmit pin
    output logic            line_o,      // block receive pin, idle high
    output logic [7:0]      got_byte_o,  // last decoded character
    output logic            got_stop_o,  // stop level seen after the data
    output logic            got_valid_o  // one-cycle strobe per frame
);
    localparam int BIT = 32; // core clocks per bit
    logic [8:0] sh;          // data bits then stop, lsb first
    initial begin
        line_o = 1'b1;
        got_valid_o = 1'b0;
    end
    // ----------------------------------------
    // send: start, data lsb first, parity if pen, one stop
    // ----------------------------------------
    task automatic send(input logic [7:0] d, input logic pen, input logic pb, input logic stp);
        logic [10:0] f;
        f = {stp, pb, d, 1'b0};
        @(posedge core_clk_i);
        for (int i = 0; i < 11; i++) begin
            if (i != 9 || pen) begin
                line_o <= f[i];
                repeat (BIT) @(posedge core_clk_i);
            end
        end
        line_o <= 1'b1; // released line rests high
    endtask : send
    // ----------------------------------------
    // decode: mid-bit samples; no parity slot expected
    // ----------------------------------------
    always begin
        @(negedge line_i);
        repeat (BIT / 2) @(posedge core_clk_i);
        for (int i = 0; i < 9; i++) begin
            repeat (BIT) @(posedge core_clk_i);
            sh = {line_i, sh[8:1]};
        end
        got_byte_o  <= sh[7:0];
        got_stop_o  <= sh[8];
        got_valid_o <= 1'b1;
        @(posedge core_clk_i);
        got_valid_o <= 1'b0;
    end
endmodule : uag_remote_node

// File: tb_uag_serial.sv
/* self-checking bench for the serial block with a remote node model.
   assumes k = 8 with base select core/2, later the timer at the same rate, so one bit is 32 clocks. */
`timescale 1ns/1ps
module tb_uag_serial;
    import uag_pkg::*;
    logic       core_clk = 1'b0, resetn = 1'b0, wr_en = 1'b0, rd_en = 1'b0, rd_seen = 1'b0, tmr = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00, rdata, got_byte, d;
    logic       txd, rxd, tx_done, rx_done, got_stop, got_valid;
    int         fail_count = 0, check_count = 0;
    time        t0;          // start of the current transmit write
    logic [8:0] rd_q[$], tx_q[$]; // expected read data, expected {stop, byte}
    uag_serial i_dut (.core_clk_i(core_clk), .resetn_i(resetn), .addr_i(addr), .wr_data_i(wdata),
        .wr_en_i(wr_en), .rd_en_i(rd_en), .rd_data_o(rdata), .serial_in_pin_i(rxd),
        .ext_timer_output_i(tmr), .serial_out_pin_o(txd), .tx_done_irq_o(tx_done), .rx_done_irq_o(rx_done));
    uag_remote_node i_remote (.core_clk_i(core_clk), .line_i(txd), .line_o(rxd), .got_byte_o(got_byte),
        .got_stop_o(got_stop), .got_valid_o(got_valid));
    initial forever #10 core_clk = ~core_clk;
    // timer output rises every two clocks, the same base rate as core/2
    always @(posedge core_clk) tmr <= ~tmr;
    task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    // watcher: read data one cycle after the strobe, decoded frames from the remote
    always @(posedge core_clk) begin
        if (rd_seen) chk({1'b0, rdata}, rd_q.pop_front(), "read data");
        rd_seen = rd_en;
        if (got_valid) chk({got_stop, got_byte}, tx_q.pop_front(), "sent frame");
    end
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge core_clk);
        addr  <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge core_clk);
        wr_en <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge core_clk);
        addr  <= a;
        rd_en <= 1'b1;
        rd_q.push_back({1'b0, e});
        @(posedge core_clk);
        rd_en <= 1'b0;
    endtask : rd
    // bounded wait for a done pulse; a missing pulse is a mismatch
    task automatic wait_irq(input logic rx);
        int n;
        for (n = 0; n < 1000; n++) begin
            @(posedge core_clk);
            if ((rx ? rx_done : tx_done) === 1'b1) break;
        end
        chk(9'(n < 1000), 9'h001, "done pulse");
    endtask : wait_irq
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : results
    initial begin
        #400_000;
        fail_count++;
        results();
    end
    initial begin
        void'($urandom(32'h86cf04a2));
        repeat (12) @(posedge core_clk);
        resetn <= 1'b1;
        rd(UAG_A_MODE, UAG_MODE_RST);
        rd(UAG_A_BAUD, UAG_BAUD_RST);
        rd(UAG_A_ERR, 8'h00);
        rd(3'h7, 8'h00);
        wr(UAG_A_BAUD, 8'h48);
        wr(UAG_A_MODE, 8'h80);
        wr(UAG_A_MODE, 8'he4);
        rd(UAG_A_MODE, 8'he5);
        // three frames, each written 40 idle clocks and a mode write after the previous done pulse
        for (int i = 0; i < 3; i++) begin
            d = 8'($urandom);
            tx_q.push_back({1'b1, d});
            wr(UAG_A_MODE, 8'he4 | {6'h00, i[0], 1'b0});
            t0 = $time;
            wr(UAG_A_TXS, d);
            wait_irq(1'b0);
            // one bit is 32 clocks of 20 ns: 10 bits, 11 with two stops
            chk(9'(($time - t0) / 640), 9'(10 + i[0]), "frame length");
            repeat (40) @(posedge core_clk);
            chk({8'h00, txd}, 9'h001, "idle line");
        end
        wr(UAG_A_BAUD, 8'h08);
        d = 8'($urandom);
        fork i_remote.send(d, 1'b0, 1'b0, 1'b1); wait_irq(1'b1); join
        rd(UAG_A_ERR, 8'h00);
        rd(UAG_A_RXB, d);
        // stop bit low: framing error, then the flag read clears
        fork i_remote.send(~d, 1'b0, 1'b0, 1'b0); wait_irq(1'b1); join
        rd(UAG_A_ERR, 8'h02);
        rd(UAG_A_ERR, 8'h00);
        rd(UAG_A_RXB, ~d);
        // even parity: a bad parity frame left unread, then a good one that overruns
        wr(UAG_A_MODE, 8'hfc);
        fork i_remote.send(d, 1'b1, ~^d, 1'b1); wait_irq(1'b1); join
        fork i_remote.send(~d, 1'b1, ^d, 1'b1); wait_irq(1'b1); join
        rd(UAG_A_ERR, 8'h05);
        rd(UAG_A_RXB, d);
        // odd parity: a correct frame leaves no flag
        wr(UAG_A_MODE, 8'hf4);
        fork i_remote.send(d, 1'b1, ~^d, 1'b1); wait_irq(1'b1); join
        rd(UAG_A_ERR, 8'h00);
        rd(UAG_A_RXB, d);
        results();
    end
endmodule : tb_uag_serial
